// ===== verilog/nvmeav_seq.sv
// Command sequencer for flash and data EEPROM: erase abort on both, erase verify on the flash only
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module nvmeav_seq
  import nvmeav_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 16,
  parameter int BLK_W = 1,
  parameter int TW = 8,
  parameter int ERASE_TICKS = 16,
  parameter int PROG_TICKS = 4
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Array write that starts a sequence
  input wire logic arr_wr,
  input wire logic arr_eeprom,
  input wire logic [BLK_W-1:0] arr_blk,
  // Verify read port to the flash array
  output logic vfy_rd_q,
  output logic [AW-1:0] vfy_addr_q,
  input wire logic [DW-1:0] vfy_rdata,
  output logic [MRG_W-1:0] vfy_margin_q,
  // Status outputs
  output logic [(1<<BLK_W)-1:0] erase_act_q,
  output logic irq_q
);
  localparam int NBLK = 1 << BLK_W;
  localparam int NADDR = 1 << AW;
  localparam int VW = AW + 5;
  localparam logic [VW-1:0] VFY_LAST = VW'(NADDR + VFY_EXTRA - 2);
  localparam logic [VW-1:0] SCAN_LO = VW'(VFY_PRE);
  localparam logic [VW-1:0] SCAN_HI = VW'(VFY_PRE + NADDR - 1);
  localparam logic [TW-1:0] ERASE_LAST = TW'(ERASE_TICKS - 1);
  localparam logic [TW-1:0] PROG_LAST = TW'(PROG_TICKS - 1);

  nvmeav_seq_type sq_q;
  nvmeav_eng_type st_q;
  logic tgt_q, ptgt_q, etgt_q, pend_q, cmd_buffer_empty_flag_q, access_error_flag_q, blank_q;
  logic mod_q, abrt_q, cut_q, vbad_q, vchk_q;
  logic [BLK_W-1:0] blk_q, pblk_q;
  logic [7:0] flash_command_reg_q, eeprom_command_reg_q, pcmd_q, fdiv_q, ediv_q;
  logic [MRG_W-1:0] mrg_q;
  logic [TW-1:0] tcnt_q;
  logic [2:0] acnt_q;
  logic [VW-1:0] vcnt_q;
  logic [1:0] irq_sts_q, irq_mask_q;
  logic done_prev_q, err_prev_q;
  logic fl_tick, ee_tick, tick;

  ////////////////////////////////////////////////////////////////////////////
  // Erase timing ticks, one divider per array
  nvmeav_tick #(.W(DIV_W)) u_fl_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .div(fdiv_q[DIV_W-1:0]),
    .tick_q(fl_tick)
  );
  nvmeav_tick #(.W(DIV_W)) u_ee_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .div(ediv_q[DIV_W-1:0]),
    .tick_q(ee_tick)
  );
  assign tick = etgt_q ? ee_tick : fl_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of register and sequence events
  logic wr_fst, wr_est, st_wr, cmd_wr_ok, go, cmd_ok, launch, bad_cmd;
  logic abort_busy, seq_start, seq_err, cmd_complete_flag, bad_now;
  logic take_idle, take_abort, take_more, take, abort_fin, cut_fin, erase_end;
  logic [7:0] cur_cmd;

  assign wr_fst = reg_wr && (reg_addr == ADDR_FL_STATUS);
  assign wr_est = reg_wr && (reg_addr == ADDR_EE_STATUS);
  assign st_wr = tgt_q ? wr_est : wr_fst;
  assign cmd_wr_ok = (sq_q == SQ_ADDR) && reg_wr &&
                     (reg_addr == (tgt_q ? ADDR_EE_CMD : ADDR_FL_CMD));
  assign cur_cmd = tgt_q ? eeprom_command_reg_q : flash_command_reg_q;
  // Buffer flag written to one launches the held command
  assign go = (sq_q == SQ_CMD) && st_wr && reg_wdata[BIT_BUF_EMPTY];
  assign cmd_ok = (cur_cmd == CMD_ABORT) || (cur_cmd == CMD_ERASE) ||
                  ((cur_cmd == CMD_VERIFY) && !tgt_q) ||
                  ((cur_cmd == CMD_MODIFY) && tgt_q);
  assign launch = go && cmd_ok;
  assign bad_cmd = go && !cmd_ok;
  assign abort_busy = (pend_q && (pcmd_q == CMD_ABORT)) || abrt_q || (st_q == S_ABORT);
  assign seq_start = arr_wr && (sq_q == SQ_IDLE) && cmd_buffer_empty_flag_q && !access_error_flag_q && !abort_busy;
  assign seq_err = arr_wr && abort_busy;
  // Engine accepts the buffered command
  assign take_idle = pend_q && (st_q == S_IDLE);
  assign take_abort = pend_q && (pcmd_q == CMD_ABORT) && !abrt_q &&
                      ((st_q == S_ERASE) || (st_q == S_PROG));
  assign take_more = pend_q && (pcmd_q == CMD_ERASE) && (st_q == S_ERASE) &&
                     !etgt_q && !ptgt_q && !mod_q && !abrt_q;
  assign take = take_idle || take_abort || take_more;
  assign abort_fin = ((st_q == S_ABORT) && (acnt_q == ABORT_LAST)) ||
                     ((st_q == S_PROG) && abrt_q && tick && (tcnt_q == PROG_LAST));
  assign cut_fin = (st_q == S_ABORT) && (acnt_q == ABORT_LAST) && cut_q;
  assign erase_end = ((st_q == S_ERASE) && tick && !take_more &&
                      ((tcnt_q == ERASE_LAST) ? !mod_q : abrt_q)) ||
                     ((st_q == S_PROG) && tick && (tcnt_q == PROG_LAST));
  assign cmd_complete_flag = (st_q == S_IDLE) && !pend_q;
  assign bad_now = vchk_q && (vfy_rdata != {DW{1'b1}});

  ////////////////////////////////////////////////////////////////////////////
  // Command write sequence: start write, command write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sq_q <= SQ_IDLE;
      tgt_q <= 1'b0;
      blk_q <= '0;
      flash_command_reg_q <= RST_BYTE;
      eeprom_command_reg_q <= RST_BYTE;
    end else if (ce) begin
      case (sq_q)
        SQ_IDLE: begin
          // Only the target array and block are kept
          if (seq_start) begin
            sq_q <= SQ_ADDR;
            tgt_q <= arr_eeprom;
            blk_q <= arr_blk;
          end
        end
        SQ_ADDR: begin
          if (cmd_wr_ok) begin
            sq_q <= SQ_CMD;
            if (tgt_q) begin
              eeprom_command_reg_q <= reg_wdata;
            end else begin
              flash_command_reg_q <= reg_wdata;
            end
          end
        end
        SQ_CMD: begin
          if (go) begin
            sq_q <= SQ_IDLE;
          end
        end
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command buffer and buffer empty flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pcmd_q <= RST_BYTE;
      ptgt_q <= 1'b0;
      pblk_q <= '0;
      cmd_buffer_empty_flag_q <= 1'b1;
    end else if (ce) begin
      if (launch) begin
        pend_q <= 1'b1;
        pcmd_q <= cur_cmd;
        ptgt_q <= tgt_q;
        pblk_q <= blk_q;
        cmd_buffer_empty_flag_q <= 1'b0;
      end else if (take) begin
        // Nothing may queue behind an abort
        pend_q <= 1'b0;
        cmd_buffer_empty_flag_q <= (pcmd_q != CMD_ABORT);
      end else if (abort_fin) begin
        cmd_buffer_empty_flag_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command engine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      etgt_q <= 1'b0;
      mod_q <= 1'b0;
      abrt_q <= 1'b0;
      cut_q <= 1'b0;
      tcnt_q <= '0;
      acnt_q <= '0;
      vcnt_q <= '0;
    end else if (ce) begin
      case (st_q)
        S_IDLE: begin
          if (pend_q) begin
            etgt_q <= ptgt_q;
            mod_q <= (pcmd_q == CMD_MODIFY);
            cut_q <= 1'b0;
            tcnt_q <= '0;
            acnt_q <= '0;
            vcnt_q <= '0;
            if (pcmd_q == CMD_VERIFY) begin
              st_q <= S_VERIFY;
            end else if (pcmd_q == CMD_ABORT) begin
              st_q <= S_ABORT;
            end else begin
              st_q <= S_ERASE;
            end
          end
        end
        S_ERASE: begin
          if (take_abort) begin
            abrt_q <= 1'b1;
          end
          if (take_more) begin
            tcnt_q <= '0;
          end else if (tick) begin
            if (tcnt_q == ERASE_LAST) begin
              // Erase done on its own, no error
              tcnt_q <= '0;
              if (mod_q) begin
                st_q <= S_PROG;
              end else if (abrt_q) begin
                st_q <= S_ABORT;
              end else begin
                st_q <= S_IDLE;
              end
            end else if (abrt_q) begin
              // Stop at the next tick, mark as cut short
              st_q <= S_ABORT;
              cut_q <= 1'b1;
            end else begin
              tcnt_q <= tcnt_q + 1'b1;
            end
          end
        end
        S_PROG: begin
          // Abort is taken but the program step runs out
          if (take_abort) begin
            abrt_q <= 1'b1;
          end
          if (tick) begin
            if (tcnt_q == PROG_LAST) begin
              st_q <= S_IDLE;
              abrt_q <= 1'b0;
            end else begin
              tcnt_q <= tcnt_q + 1'b1;
            end
          end
        end
        S_VERIFY: begin
          vcnt_q <= vcnt_q + 1'b1;
          if (bad_now || (vcnt_q == VFY_LAST)) begin
            st_q <= S_IDLE;
          end
        end
        S_ABORT: begin
          acnt_q <= acnt_q + 1'b1;
          if (acnt_q == ABORT_LAST) begin
            st_q <= S_IDLE;
            abrt_q <= 1'b0;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active erase per block, all cleared together by one abort
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      erase_act_q <= '0;
    end else if (ce) begin
      if (erase_end) begin
        erase_act_q <= '0;
      end else if ((take_idle && ((pcmd_q == CMD_ERASE) || (pcmd_q == CMD_MODIFY))) ||
                   take_more) begin
        erase_act_q[pblk_q] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verify scan: one address a cycle, data checked a cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vfy_rd_q <= 1'b0;
      vfy_addr_q <= '0;
      vchk_q <= 1'b0;
      vbad_q <= 1'b0;
      vfy_margin_q <= '0;
    end else if (ce) begin
      vfy_rd_q <= (st_q == S_VERIFY) && !vbad_q && !bad_now &&
                  (vcnt_q >= SCAN_LO) && (vcnt_q <= SCAN_HI);
      vfy_addr_q <= AW'(vcnt_q - SCAN_LO);
      vchk_q <= vfy_rd_q && !bad_now;
      vfy_margin_q <= (st_q == S_VERIFY) ? mrg_q : '0;
      if (take_idle) begin
        vbad_q <= 1'b0;
      end else if (bad_now) begin
        vbad_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access error and blank flags, set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      access_error_flag_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (ce) begin
      if (seq_err || bad_cmd || cut_fin) begin
        access_error_flag_q <= 1'b1;
      end else if ((wr_fst || wr_est) && reg_wdata[BIT_ACC_ERR]) begin
        access_error_flag_q <= 1'b0;
      end
      if (take_idle && (pcmd_q == CMD_VERIFY)) begin
        blank_q <= 1'b0;
      end else if ((st_q == S_VERIFY) && (vcnt_q == VFY_LAST) && !bad_now) begin
        blank_q <= !vbad_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers written by software
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fdiv_q <= RST_BYTE;
      ediv_q <= RST_BYTE;
      mrg_q <= '0;
      irq_mask_q <= RST_IRQ;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        ADDR_FL_DIV: fdiv_q <= reg_wdata;
        ADDR_EE_DIV: ediv_q <= reg_wdata;
        ADDR_FL_TEST: mrg_q <= reg_wdata[MRG_W-1:0];
        ADDR_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky events, cleared by read, set wins
  logic rd_irq;
  assign rd_irq = reg_rd && (reg_addr == ADDR_IRQ_STATUS);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_sts_q <= RST_IRQ;
      done_prev_q <= 1'b1;
      err_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      done_prev_q <= cmd_complete_flag;
      err_prev_q <= access_error_flag_q;
      irq_sts_q[IRQ_DONE] <= (cmd_complete_flag && !done_prev_q) || (irq_sts_q[IRQ_DONE] && !rd_irq);
      irq_sts_q[IRQ_ERR] <= (access_error_flag_q && !err_prev_q) || (irq_sts_q[IRQ_ERR] && !rd_irq);
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the read strobe
  logic [7:0] flash_status_reg_w, eeprom_status_reg_w;
  always_comb begin
    flash_status_reg_w = '0;
    flash_status_reg_w[BIT_BUF_EMPTY] = cmd_buffer_empty_flag_q;
    flash_status_reg_w[BIT_CMD_DONE] = cmd_complete_flag;
    flash_status_reg_w[BIT_ACC_ERR] = access_error_flag_q;
    eeprom_status_reg_w = flash_status_reg_w;
    flash_status_reg_w[BIT_BLANK] = blank_q;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_q <= RST_BYTE;
    end else if (ce) begin
      reg_rdata_q <= RST_BYTE;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_FL_STATUS: reg_rdata_q <= flash_status_reg_w;
          ADDR_EE_STATUS: reg_rdata_q <= eeprom_status_reg_w;
          ADDR_FL_CMD: reg_rdata_q <= flash_command_reg_q;
          ADDR_EE_CMD: reg_rdata_q <= eeprom_command_reg_q;
          ADDR_FL_TEST: reg_rdata_q <= {{(8-MRG_W){1'b0}}, mrg_q};
          ADDR_FL_DIV: reg_rdata_q <= fdiv_q;
          ADDR_EE_DIV: reg_rdata_q <= ediv_q;
          ADDR_IRQ_STATUS: reg_rdata_q <= {6'h00, irq_sts_q};
          ADDR_IRQ_MASK: reg_rdata_q <= {6'h00, irq_mask_q};
          default: reg_rdata_q <= RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters: cycles from launch to complete flag
  logic [15:0] alen_q, vlen_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alen_q <= '0;
      vlen_q <= '0;
    end else if (ce) begin
      // A program step that an abort lets finish is outside the abort bound
      alen_q <= (launch && cur_cmd == CMD_ABORT) ? 16'h0001 :
                ((alen_q != '0) && !cmd_complete_flag && (st_q != S_PROG)) ? alen_q + 1'b1 : '0;
      vlen_q <= (launch && cur_cmd == CMD_VERIFY) ? 16'h0001 :
                ((vlen_q != '0) && !cmd_complete_flag) ? vlen_q + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_abort_launch;
    ce && launch && (cur_cmd == CMD_ABORT);
  endsequence
  sequence s_abort_held;
    pend_q && !cmd_buffer_empty_flag_q && (pcmd_q == CMD_ABORT);
  endsequence
  property p_abort_launch;
    s_abort_launch |=> s_abort_held;
  endproperty
  a_abort_launch: assert property (p_abort_launch) else $error("abort not buffered");
  property p_abort_err;
    (ce && cut_fin) |=> access_error_flag_q;
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("cut erase left no error");
  property p_abort_clean;
    (ce && abort_fin && !cut_q && !access_error_flag_q && !arr_wr && !go) |=> !access_error_flag_q;
  endproperty
  a_abort_clean: assert property (p_abort_clean) else $error("clean abort set error");
  property p_prog_keeps;
    (ce && st_q == S_PROG && abrt_q) |=> (st_q == S_PROG || st_q == S_IDLE) && !cut_q;
  endproperty
  a_prog_keeps: assert property (p_prog_keeps) else $error("program step cut");
  // Length counters read one above the cycles elapsed since launch
  property p_abort_time;
    (alen_q != '0) |->
      alen_q <= 16'(ABORT_TICK_MAX *
                    ((etgt_q ? ediv_q[DIV_W-1:0] : fdiv_q[DIV_W-1:0]) + 1) +
                    ABORT_BUS_MAX + 1);
  endproperty
  a_abort_time: assert property (p_abort_time) else $error("abort too slow");
  property p_no_buffer;
    abort_busy |-> !cmd_buffer_empty_flag_q;
  endproperty
  a_no_buffer: assert property (p_no_buffer) else $error("buffer open during abort");
  property p_seq_err;
    (ce && arr_wr && abort_busy) |=> access_error_flag_q;
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("start during abort missed");
  property p_all_stop;
    (st_q == S_ABORT) |-> (erase_act_q == '0);
  endproperty
  a_all_stop: assert property (p_all_stop) else $error("block still erasing");
  property p_vfy_time;
    (cmd_complete_flag && vlen_q != '0 && blank_q) |-> (vlen_q == 16'(NADDR + VFY_EXTRA + 1));
  endproperty
  a_vfy_time: assert property (p_vfy_time) else $error("verify length wrong");
  property p_vfy_stop;
    (ce && bad_now && st_q == S_VERIFY) |=> (st_q == S_IDLE) && !blank_q;
  endproperty
  a_vfy_stop: assert property (p_vfy_stop) else $error("verify ran past bad word");
  property p_margin;
    (ce && st_q == S_VERIFY) |=> (vfy_margin_q == $past(mrg_q));
  endproperty
  a_margin: assert property (p_margin) else $error("verify margin wrong");
endmodule : nvmeav_seq

// ===== common/nvmeav_pkg.sv
// Constants and types for the nonvolatile memory command sequencer
package nvmeav_pkg;
  // Register indices
  localparam logic [3:0] ADDR_FL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_FL_CMD = 4'h1;
  localparam logic [3:0] ADDR_FL_TEST = 4'h2;
  localparam logic [3:0] ADDR_FL_DIV = 4'h3;
  localparam logic [3:0] ADDR_EE_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EE_CMD = 4'h5;
  localparam logic [3:0] ADDR_EE_DIV = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  // Status bit positions
  localparam int BIT_BUF_EMPTY = 7;
  localparam int BIT_CMD_DONE = 6;
  localparam int BIT_ACC_ERR = 4;
  localparam int BIT_BLANK = 2;
  // Interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  // Command codes
  localparam logic [7:0] CMD_ABORT = 8'h47;
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] CMD_MODIFY = 8'h60;
  // Field widths and reset values
  localparam int MRG_W = 2;
  localparam int DIV_W = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Abort timing bound and actual bus cycles spent after the stop tick
  localparam int ABORT_TICK_MAX = 4;
  localparam int ABORT_BUS_MAX = 5;
  localparam logic [2:0] ABORT_LAST = 3'h2;
  // Erase verify overhead cycles and scan start offset
  localparam int VFY_EXTRA = 14;
  localparam int VFY_PRE = 10;
  // Command engine states, Gray along the usual path
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ERASE = 3'b001,
    S_PROG = 3'b011,
    S_VERIFY = 3'b010,
    S_ABORT = 3'b110
  } nvmeav_eng_type;
  // Command write sequence states
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_ADDR = 2'b01,
    SQ_CMD = 2'b11
  } nvmeav_seq_type;
endpackage : nvmeav_pkg

// ===== verilog/nvmeav_tick.sv
// Erase timing clock divider, one tick pulse per divided period
`timescale 1ns/1ps
module nvmeav_tick #(
  parameter int W = 6
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Divider setting, period is div plus one cycles
  input wire logic [W-1:0] div,
  // Tick pulse
  output logic tick_q
);
  logic [W-1:0] cnt_q;

  // Count up to div, pulse and wrap
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q >= div) begin
        cnt_q <= '0;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end
endmodule : nvmeav_tick

// ===== verification/nvmeav_array_model.sv
// Flash array model that answers erase verify reads
`timescale 1ns/1ps
module nvmeav_array_model #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Verify read port
  input wire logic vfy_rd_q,
  input wire logic [AW-1:0] vfy_addr_q,
  input wire logic [1:0] vfy_margin_q,
  output logic [DW-1:0] vfy_rdata,
  // Dirty word placement and observation
  input wire logic bad_en,
  input wire logic [AW-1:0] bad_addr,
  input wire logic [DW-1:0] bad_word,
  output logic [1:0] margin_seen_q,
  output logic [15:0] reads_q
);
  logic tog_q;
  ////////////////////////////////////////
  // Answer in the cycle after a read, a changing non-blank pattern otherwise
  always_ff @(posedge mclk) begin
    tog_q <= ~tog_q;
    if (!rst_n) begin
      tog_q <= 1'b0;
      vfy_rdata <= {(DW/2){2'b10}};
      reads_q <= 16'h0000;
      margin_seen_q <= 2'h0;
    end else if (vfy_rd_q) begin
      vfy_rdata <= (bad_en && vfy_addr_q == bad_addr) ? bad_word : {DW{1'b1}};
      reads_q <= reads_q + 16'h0001;
      margin_seen_q <= vfy_margin_q;
    end else begin
      vfy_rdata <= tog_q ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
    end
  end
endmodule : nvmeav_array_model

// ===== verification/nvmeav_seq_bench.sv
// Self-checking bench for the nonvolatile command sequencer
`timescale 1ns/1ps
module nvmeav_seq_bench;
  import nvmeav_pkg::*;
  localparam int AW = 4;
  localparam int NV = (1 << AW) + VFY_EXTRA;
  localparam int DIV = 3;
  localparam int AB = ABORT_TICK_MAX * (DIV + 1) + ABORT_BUS_MAX;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic arr_wr = 1'b0;
  logic arr_eeprom = 1'b0;
  logic [0:0] arr_blk = 1'b0;
  logic bad_en = 1'b0;
  logic [AW-1:0] bad_addr = '0;
  logic [15:0] bad_word = 16'h0000;
  logic [7:0] reg_rdata_q, d;
  logic vfy_rd_q, irq_q;
  logic [AW-1:0] vfy_addr_q;
  logic [15:0] vfy_rdata, reads_q, r0;
  logic [1:0] vfy_margin_q, margin_seen_q, erase_act_q, m;
  int n_errors = 0;
  int compares = 0;
  int c;
  logic [31:0] lf;

  always #20 mclk = ~mclk;

  nvmeav_seq #(.AW(AW), .DW(16), .BLK_W(1), .ERASE_TICKS(8), .PROG_TICKS(16)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .arr_wr(arr_wr),
    .arr_eeprom(arr_eeprom), .arr_blk(arr_blk), .vfy_rd_q(vfy_rd_q), .vfy_addr_q(vfy_addr_q),
    .vfy_rdata(vfy_rdata), .vfy_margin_q(vfy_margin_q), .erase_act_q(erase_act_q),
    .irq_q(irq_q));
  nvmeav_array_model #(.AW(AW), .DW(16)) arr (
    .mclk(mclk), .rst_n(rst_n), .vfy_rd_q(vfy_rd_q), .vfy_addr_q(vfy_addr_q),
    .vfy_margin_q(vfy_margin_q), .vfy_rdata(vfy_rdata), .bad_en(bad_en),
    .bad_addr(bad_addr), .bad_word(bad_word), .margin_seen_q(margin_seen_q),
    .reads_q(reads_q));

  ////////////////////////////////////////
  // Pseudo-random source, fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
  endfunction : lfsr
  // Compare and report
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // Verdict and stop
  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask : rd
  // Array write that opens a sequence, no address or data
  task automatic start(input logic ee, input logic b);
    @(posedge mclk);
    arr_wr <= 1'b1;
    arr_eeprom <= ee;
    arr_blk <= b;
    @(posedge mclk);
    arr_wr <= 1'b0;
  endtask : start
  task automatic seq(input logic ee, input logic b, input logic [7:0] code);
    start(ee, b);
    wr(ee ? ADDR_EE_CMD : ADDR_FL_CMD, code);
    wr(ee ? ADDR_EE_STATUS : ADDR_FL_STATUS, 8'h80);
  endtask : seq
  // Poll status each cycle, c counts cycles from the launch edge
  task automatic wait_done(input logic ee, input logic ab, output int c);
    @(posedge mclk);
    reg_addr <= ee ? ADDR_EE_STATUS : ADDR_FL_STATUS;
    reg_rd <= 1'b1;
    c = 1;
    do begin
      @(posedge mclk);
      #1 c++;
      if (ab && reg_rdata_q[BIT_CMD_DONE] !== 1'b1) chk("buf_empty", 0, reg_rdata_q[7]);
    end while (reg_rdata_q[BIT_CMD_DONE] !== 1'b1 && c < 300);
    reg_rd <= 1'b0;
    if (c >= 300) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_done

  ////////////////////////////////////////
  // Main sequence
  initial begin
    lf = 32'd80082;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADDR_FL_STATUS, d);
    chk("reset_status", 8'hc0, d);
    rd(4'hf, d);
    chk("unmapped", 0, d);
    // A write while the enable is low must be lost
    @(posedge mclk);
    ce <= 1'b0;
    wr(ADDR_FL_DIV, 8'h3f);
    ce <= 1'b1;
    rd(ADDR_FL_DIV, d);
    chk("ce_freeze", 0, d);
    wr(ADDR_FL_DIV, DIV);
    wr(ADDR_EE_DIV, DIV);
    wr(ADDR_IRQ_MASK, 8'h02);
    // Blank block, then a dirty word at a random place
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      m = lf[9:8];
      bad_en <= (i != 0);
      bad_addr <= {1'b0, lf[AW-2:0]};
      bad_word <= lf[31:16] & 16'h7fff;
      r0 = reads_q;
      wr(ADDR_FL_TEST, {6'h00, m});
      seq(0, 0, CMD_VERIFY);
      wait_done(0, 0, c);
      rd(ADDR_FL_STATUS, d);
      chk("blank", i == 0, d[BIT_BLANK]);
      chk("margin", m, margin_seen_q);
      if (i == 0) chk("vfy_time", 1, c >= NV && c <= NV + 1);
      else chk("early_stop", 1, c < NV && reads_q - r0 <= bad_addr + 2);
    end
    // Abort of two joined flash erases
    seq(0, 0, CMD_ERASE);
    seq(0, 1, CMD_ERASE);
    @(posedge mclk);
    #1 chk("erase_act", 2'b11, erase_act_q);
    seq(0, 0, CMD_ABORT);
    wait_done(0, 1, c);
    chk("abort_time", 1, c <= AB + 1);
    rd(ADDR_FL_STATUS, d);
    chk("cut_error", 1, d[BIT_ACC_ERR]);
    chk("all_stopped", 2'b00, erase_act_q);
    chk("irq_on", 1, irq_q);
    rd(ADDR_IRQ_STATUS, d);
    chk("irq_err", 1, d[IRQ_ERR]);
    wr(ADDR_FL_STATUS, 8'h10);
    rd(ADDR_IRQ_STATUS, d);
    chk("irq_clr", 0, d[IRQ_ERR]);
    chk("irq_off", 0, irq_q);
    // Cut sector is erased afresh and runs out
    seq(0, 0, CMD_ERASE);
    wait_done(0, 0, c);
    chk("reerase_done", 2'b00, erase_act_q);
    // Abort with nothing to stop leaves the error clear
    seq(0, 0, CMD_ABORT);
    wait_done(0, 1, c);
    rd(ADDR_FL_STATUS, d);
    chk("clean_abort", 0, d[BIT_ACC_ERR]);
    // Modify past its erase step, then a start while the abort is active
    seq(1, 0, CMD_MODIFY);
    repeat (45) @(posedge mclk);
    seq(1, 0, CMD_ABORT);
    start(1, 0);
    wait_done(1, 1, c);
    chk("prog_runs", 1, c > AB + 1);
    rd(ADDR_EE_STATUS, d);
    chk("busy_start", 1, d[BIT_ACC_ERR]);
    wr(ADDR_EE_STATUS, 8'h10);
    end_sim();
  end
endmodule : nvmeav_seq_bench
